//--- logic/sync_sep_regs.svh
/*
 * Register indices, field positions, reset values and timing counts of the
 * composite sync separator.
 * Assumes a 100 MHz core clock and an Avalon-MM slave with byte addressing,
 * where each register index sits at byte address four times the index.
 */
`ifndef SYNC_SEP_REGS_SVH
`define SYNC_SEP_REGS_SVH

// ****************************************************************
// Register indices and field positions
// ****************************************************************
`define SYNC_SEP_IDX_THRESH   6'h0e
`define SYNC_SEP_IDX_PATH     6'h0f
`define SYNC_SEP_IDX_SRC      6'h10
`define SYNC_SEP_IDX_STATUS   6'h16
`define SYNC_SEP_IDX_COUNT    6'h17
`define SYNC_SEP_BIT_DIG_SEL  1
`define SYNC_SEP_BIT_SOG_SEL  3
`define SYNC_SEP_BIT_VS_OVR   1
`define SYNC_SEP_BIT_VS_SEP   0
`define SYNC_SEP_BIT_AVS      5
`define SYNC_SEP_BIT_SEP_VS   0

// ****************************************************************
// Reset values
// ****************************************************************
`define SYNC_SEP_THRESH_RST   8'h20
`define SYNC_SEP_BIT_RST      1'b0

// ****************************************************************
// Timing
// ****************************************************************
`define SYNC_SEP_CORE_CLK_KHZ 100000
`define SYNC_SEP_TICK_KHZ     5000
`define SYNC_SEP_TICK_DIV     (`SYNC_SEP_CORE_CLK_KHZ / `SYNC_SEP_TICK_KHZ)
`define SYNC_SEP_COUNT_MAX    8'hff

`endif

//--- logic/sync_sep_pkg.sv
/*
 * Types shared by the composite sync separator modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sync_sep_pkg;

  typedef enum logic {
    SEEK_VSYNC,
    HOLD_VSYNC
  } sep_state_t;

  typedef logic [7:0] count_t;

endpackage : sync_sep_pkg

//--- logic/sep_tick_gen.sv
/*
 * Divides the core clock down to the separator counting rate.
 * Assumes a free running core clock and a synchronous active high reset.
 */
`timescale 1ns/1ns
`include "sync_sep_regs.svh"

module sep_tick_gen (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  output logic      o_tick
);

  localparam int     TICK_GAP = `SYNC_SEP_TICK_DIV;
  localparam int     TICK_REST = TICK_GAP - 8;
  localparam logic [4:0] LAST = 5'(`SYNC_SEP_TICK_DIV - 1);

  logic [4:0] div_count;

  // ****************************************************************
  // Divider
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_count <= 5'h00;
      o_tick    <= 1'b0;
    end else begin
      o_tick <= (div_count == LAST);
      if (div_count == LAST) begin
        div_count <= 5'h00;
      end else begin
        div_count <= div_count + 5'h01;
      end
    end
  end

  a_tick_spacing: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_tick |=> !o_tick [*8] ##TICK_REST o_tick)
    else $error("Separator tick spacing is wrong.");

endmodule : sep_tick_gen

//--- logic/sync_sep_counter.sv
/*
 * Eight bit up/down counter that finds the long vertical pulse inside a
 * composite sync and then confirms that it has gone away.
 * Assumes an active high composite sync synchronous to the core clock and
 * a one cycle tick at the counting rate.
 */
`timescale 1ns/1ns
`include "sync_sep_regs.svh"

module sync_sep_counter (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic       i_csync,
  input  wire logic [7:0] i_threshold,
  output logic            o_vsync,
  output logic [7:0]      o_count
);

  sync_sep_pkg::sep_state_t state;

  function automatic sync_sep_pkg::count_t sat_inc(
    input sync_sep_pkg::count_t v);
    sat_inc = (v == `SYNC_SEP_COUNT_MAX) ? v : v + 8'h01;
  endfunction : sat_inc

  // ****************************************************************
  // Detection and release sequence
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state   <= sync_sep_pkg::SEEK_VSYNC;
      o_count <= 8'h00;
      o_vsync <= 1'b0;
    end else if (i_tick) begin
      case (state)
        sync_sep_pkg::SEEK_VSYNC: begin
          if (i_csync && sat_inc(o_count) > i_threshold) begin
            o_vsync <= 1'b1;
            o_count <= 8'h00;
            state   <= sync_sep_pkg::HOLD_VSYNC;
          end else if (i_csync) begin
            o_count <= sat_inc(o_count);
          end else if (o_count != 8'h00) begin
            o_count <= o_count - 8'h01;
          end
        end
        sync_sep_pkg::HOLD_VSYNC: begin
          if (!i_csync && sat_inc(o_count) >= i_threshold) begin
            o_vsync <= 1'b0;
            o_count <= 8'h00;
            state   <= sync_sep_pkg::SEEK_VSYNC;
          end else if (!i_csync) begin
            o_count <= sat_inc(o_count);
          end
        end
        default: begin
          state   <= sync_sep_pkg::SEEK_VSYNC;
          o_count <= 8'h00;
          o_vsync <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_count_down_floor: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (i_tick && !i_csync && state == sync_sep_pkg::SEEK_VSYNC)
    |=> o_count == (($past(o_count) == 8'h00) ? 8'h00
                    : $past(o_count) - 8'h01))
    else $error("Counter did not count down to zero.");

  a_no_wrap_up: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_count == 8'hff && i_tick && i_csync
     && state == sync_sep_pkg::SEEK_VSYNC)
    |=> o_count == 8'hff || o_vsync)
    else $error("Counter wrapped past its top.");

  a_detect_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_vsync) |-> o_count == 8'h00
      && $past(o_count) >= $past(i_threshold))
    else $error("Detection without clear or below threshold.");

  a_end_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_vsync) |-> o_count == 8'h00
      && $past(o_count) + 9'h001 >= {1'b0, $past(i_threshold)})
    else $error("Release without clear or before threshold.");

  a_hold_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == sync_sep_pkg::HOLD_VSYNC && i_csync)
    |=> $stable(o_count) && o_vsync)
    else $error("Counter moved while the pulse was present.");

  c_detect: cover property (@(posedge i_core_clk) $rose(o_vsync));
  c_release: cover property (@(posedge i_core_clk) $fell(o_vsync));
  c_saturate: cover property (@(posedge i_core_clk) o_count == 8'hff);

endmodule : sync_sep_counter

//--- logic/composite_sync_separator.sv
/*
 * Digital sync processing: source multiplexers, output path multiplexers,
 * the composite sync separator and its Avalon-MM register slave.
 * Assumes all sync inputs already sliced to logic levels and synchronous to
 * the 100 MHz core clock, and a master that holds each request until it
 * sees waitrequest low.
 */
`timescale 1ns/1ns
`include "sync_sep_regs.svh"

module composite_sync_separator (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  input  wire logic        i_hsync,
  input  wire logic        i_vsync,
  input  wire logic        i_sync_on_green_input,
  input  wire logic        i_csync_active_low,
  input  wire logic        i_dig_hsync,
  input  wire logic        i_dig_vsync,
  input  wire logic        i_dig_csync,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  output logic             o_hsync,
  output logic             o_vsync,
  output logic             o_csync,
  output logic             o_active_vertical_source_flag,
  output logic             o_sep_vsync
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] threshold;
  logic       dig_sel;
  logic       sog_sel;
  logic       vs_override;
  logic       vs_sep_sel;
  logic       tick;
  logic       sep_vsync;
  logic [7:0] sep_count;
  logic       ana_hsync;
  logic       ana_csync;
  logic       ana_vsync;
  logic       csync_pulse;
  logic       next_avs;
  logic       access;
  logic       commit;
  logic [7:0] wr_byte;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    reg_index = addr[7:2];
  endfunction : reg_index

  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [5:0] idx);
    reg_hit = (addr[1:0] == 2'h0) && (reg_index(addr) == idx);
  endfunction : reg_hit

  function automatic logic addr_ok(input logic [7:0] addr);
    addr_ok = (addr[1:0] == 2'h0);
  endfunction : addr_ok

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  assign access = i_read || i_write;
  assign commit = i_write && !o_waitrequest && i_byteenable[0];
  assign wr_byte = i_writedata[7:0];

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
    end else if (access && o_waitrequest) begin
      o_waitrequest <= 1'b0;
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      threshold <= `SYNC_SEP_THRESH_RST;
    end else if (commit && reg_hit(i_address, `SYNC_SEP_IDX_THRESH)) begin
      threshold <= wr_byte;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dig_sel <= `SYNC_SEP_BIT_RST;
    end else if (commit && reg_hit(i_address, `SYNC_SEP_IDX_PATH)) begin
      dig_sel <= wr_byte[`SYNC_SEP_BIT_DIG_SEL];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sog_sel     <= `SYNC_SEP_BIT_RST;
      vs_override <= `SYNC_SEP_BIT_RST;
      vs_sep_sel  <= `SYNC_SEP_BIT_RST;
    end else if (commit && reg_hit(i_address, `SYNC_SEP_IDX_SRC)) begin
      sog_sel     <= wr_byte[`SYNC_SEP_BIT_SOG_SEL];
      vs_override <= wr_byte[`SYNC_SEP_BIT_VS_OVR];
      vs_sep_sel  <= wr_byte[`SYNC_SEP_BIT_VS_SEP];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    status_byte = 8'h00;
    status_byte[`SYNC_SEP_BIT_AVS]    = o_active_vertical_source_flag;
    status_byte[`SYNC_SEP_BIT_SEP_VS] = sep_vsync;
  end

  always_comb begin
    rd_byte = 8'h00;
    if (addr_ok(i_address)) begin
      case (reg_index(i_address))
        `SYNC_SEP_IDX_THRESH: begin
          rd_byte = threshold;
        end
        `SYNC_SEP_IDX_PATH: begin
          rd_byte[`SYNC_SEP_BIT_DIG_SEL] = dig_sel;
        end
        `SYNC_SEP_IDX_SRC: begin
          rd_byte[`SYNC_SEP_BIT_SOG_SEL] = sog_sel;
          rd_byte[`SYNC_SEP_BIT_VS_OVR]  = vs_override;
          rd_byte[`SYNC_SEP_BIT_VS_SEP]  = vs_sep_sel;
        end
        `SYNC_SEP_IDX_STATUS: begin
          rd_byte = status_byte;
        end
        `SYNC_SEP_IDX_COUNT: begin
          rd_byte = sep_count;
        end
        default: begin
          rd_byte = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && o_waitrequest) begin
      o_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************************
  // Source multiplexers
  // ****************************************************************
  assign ana_hsync = sog_sel ? i_sync_on_green_input : i_hsync;
  assign ana_csync = sog_sel ? i_sync_on_green_input : i_hsync;
  assign ana_vsync = vs_sep_sel ? sep_vsync : i_vsync;

  // Polarity is folded in here so the counter only sees active high pulses.
  assign csync_pulse = ana_csync ^ i_csync_active_low;

  // ****************************************************************
  // Separator
  // ****************************************************************
  sep_tick_gen u_tick (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .o_tick     (tick)
  );

  sync_sep_counter u_counter (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_tick      (tick),
    .i_csync     (csync_pulse),
    .i_threshold (threshold),
    .o_vsync     (sep_vsync),
    .o_count     (sep_count)
  );

  // ****************************************************************
  // Output path multiplexers and status
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_hsync <= 1'b0;
      o_vsync <= 1'b0;
      o_csync <= 1'b0;
    end else begin
      o_hsync <= dig_sel ? i_dig_hsync : ana_hsync;
      o_vsync <= dig_sel ? i_dig_vsync : ana_vsync;
      o_csync <= dig_sel ? i_dig_csync : ana_csync;
    end
  end

  assign next_avs = vs_override ? vs_sep_sel : vs_sep_sel;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_active_vertical_source_flag <= 1'b0;
      o_sep_vsync                   <= 1'b0;
    end else begin
      o_active_vertical_source_flag <= next_avs;
      o_sep_vsync                   <= sep_vsync;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_hsync_source_mux: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    !dig_sel |=> o_hsync == $past(sog_sel ? i_sync_on_green_input
                                          : i_hsync))
    else $error("Hsync source mux passed the wrong input.");

  a_csync_source_mux: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    !dig_sel |=> o_csync == $past(sog_sel ? i_sync_on_green_input
                                          : i_hsync))
    else $error("Composite source mux passed the wrong input.");

  a_vsync_source_mux: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    !dig_sel |=> o_vsync == $past(vs_sep_sel ? sep_vsync : i_vsync))
    else $error("Vsync source mux passed the wrong input.");

  a_output_path_mux: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    dig_sel |=> o_hsync == $past(i_dig_hsync)
      && o_vsync == $past(i_dig_vsync) && o_csync == $past(i_dig_csync))
    else $error("Output mux did not pass the digital path.");

  a_avs_flag_follow: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    ##1 o_active_vertical_source_flag == $past(vs_sep_sel))
    else $error("Active source flag disagrees with the selection.");

  a_bus_answer_once: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    !o_waitrequest |=> o_waitrequest)
    else $error("Waitrequest stayed low for more than one cycle.");

  a_thresh_written: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (commit && reg_hit(i_address, `SYNC_SEP_IDX_THRESH))
    |=> threshold == $past(wr_byte))
    else $error("Threshold write was lost.");

  // ****************************************************************
  // Register and bus checks
  // ****************************************************************
  a_reset_state: assert property (@(posedge i_core_clk)
    i_rst |=> o_waitrequest && o_readdata == 32'h0000_0000
      && !o_hsync && !o_vsync && !o_csync
      && !o_active_vertical_source_flag && !o_sep_vsync)
    else $error("Outputs did not take their reset values.");

  a_wait_one_state: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (access && o_waitrequest) |=> !o_waitrequest)
    else $error("Request was not answered after one wait state.");

  a_read_thresh: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (i_read && o_waitrequest && reg_hit(i_address, `SYNC_SEP_IDX_THRESH))
    |=> o_readdata == {24'h00_0000, $past(threshold)})
    else $error("Threshold read back the wrong value.");

  a_read_refused: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (i_read && o_waitrequest && !addr_ok(i_address))
    |=> o_readdata == 32'h0000_0000)
    else $error("Unaligned read returned data.");

  a_write_byte_gate: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (i_write && !o_waitrequest && !i_byteenable[0])
    |=> $stable(threshold) && $stable(dig_sel) && $stable(sog_sel)
      && $stable(vs_override) && $stable(vs_sep_sel))
    else $error("Write without low byte enable changed a register.");

  a_src_written: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (commit && reg_hit(i_address, `SYNC_SEP_IDX_SRC))
    |=> sog_sel == $past(wr_byte[`SYNC_SEP_BIT_SOG_SEL])
      && vs_override == $past(wr_byte[`SYNC_SEP_BIT_VS_OVR])
      && vs_sep_sel == $past(wr_byte[`SYNC_SEP_BIT_VS_SEP]))
    else $error("Source register write was lost.");

  a_path_written: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (commit && reg_hit(i_address, `SYNC_SEP_IDX_PATH))
    |=> dig_sel == $past(wr_byte[`SYNC_SEP_BIT_DIG_SEL]))
    else $error("Path register write was lost.");

  a_status_read: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (i_read && o_waitrequest && reg_hit(i_address, `SYNC_SEP_IDX_STATUS))
    |=> o_readdata[`SYNC_SEP_BIT_AVS] == $past(o_active_vertical_source_flag)
      && o_readdata[`SYNC_SEP_BIT_SEP_VS] == $past(sep_vsync))
    else $error("Status read back the wrong bits.");

  a_count_read: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (i_read && o_waitrequest && reg_hit(i_address, `SYNC_SEP_IDX_COUNT))
    |=> o_readdata == {24'h00_0000, $past(sep_count)})
    else $error("Count read back the wrong value.");

  a_sep_copy: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    ##1 o_sep_vsync == $past(sep_vsync))
    else $error("Separator vsync output lags wrongly.");

  c_sog_selected: cover property (@(posedge i_core_clk)
    sog_sel && !dig_sel);
  c_separator_vsync: cover property (@(posedge i_core_clk)
    vs_sep_sel && $rose(o_vsync));

endmodule : composite_sync_separator

//--- verif/sync_source_model.sv
/*
 * Graphics source model giving separate and composite sync lines.
 * Assumes the bench core clock; the composite is active high and is
 * held active through the whole vertical interval.
 */
`timescale 1ns/1ns

module sync_source_model #(
  parameter int LINE = 400,
  parameter int HW   = 40,
  parameter int VL   = 6,
  parameter int FL   = 20
) (
  input  wire logic i_core_clk,
  input  wire logic i_run,
  output logic      o_hsync,
  output logic      o_vsync,
  output logic      o_csync
);
  // ****************************************************************
  // Line and frame position
  // ****************************************************************
  int pix;
  int line;

  always_ff @(posedge i_core_clk) begin
    if (!i_run) begin
      pix  <= 0;
      line <= 0;
    end else if (pix == LINE - 1) begin
      pix  <= 0;
      line <= (line == FL - 1) ? 0 : line + 1;
    end else begin
      pix <= pix + 1;
    end
  end

  // ****************************************************************
  // Sync levels
  // ****************************************************************
  always_comb begin
    o_hsync = i_run && (pix < HW);
    o_vsync = i_run && (line < VL);
    o_csync = o_hsync || o_vsync;
  end
endmodule : sync_source_model

//--- verif/tb_composite_sync_separator.sv
/*
 * Self-checking bench of the composite sync separator.
 * Assumes the register map of sync_sep_regs.svh and one wait state.
 */
`timescale 1ns/1ns
`include "sync_sep_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module tb_composite_sync_separator;
  localparam logic [7:0] A_THR  = {`SYNC_SEP_IDX_THRESH, 2'b00};
  localparam logic [7:0] A_PATH = {`SYNC_SEP_IDX_PATH, 2'b00};
  localparam logic [7:0] A_SRC  = {`SYNC_SEP_IDX_SRC, 2'b00};
  localparam logic [7:0] A_STAT = {`SYNC_SEP_IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CNT  = {`SYNC_SEP_IDX_COUNT, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h0;
  logic        h = 1'b0, v = 1'b0, s = 1'b0, pol = 1'b0;
  logic        dh = 1'b0, dv = 1'b0, dc = 1'b0, run = 1'b0;
  logic        mh, mv, mc, oh, ov, oc, flag, sepv, wreq;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h8c4207d5;
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  sync_source_model u_sync_source_model (.i_core_clk(clk), .i_run(run),
    .o_hsync(mh), .o_vsync(mv), .o_csync(mc));

  composite_sync_separator u_composite_sync_separator (
    .i_core_clk(clk), .i_rst(rst), .i_address(adr), .i_read(rd),
    .i_write(wr), .i_writedata(wdat), .i_byteenable(be),
    .i_hsync(run ? mh : h), .i_vsync(run ? mv : v),
    .i_sync_on_green_input(run ? mc : s), .i_csync_active_low(pol),
    .i_dig_hsync(dh), .i_dig_vsync(dv), .i_dig_csync(dc),
    .o_readdata(rdat), .o_waitrequest(wreq), .o_hsync(oh), .o_vsync(ov),
    .o_csync(oc), .o_active_vertical_source_flag(flag),
    .o_sep_vsync(sepv));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt

  function automatic logic pick(input logic dig, sel, a, b, d);
    return dig ? d : (sel ? a : b);
  endfunction : pick

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w; wr <= w; adr <= a; wdat <= d; be <= b;
    do begin @(posedge clk); n++; end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
    `CHK(n, 2)
  endtask : bus

  task automatic wait_sep(input logic lvl, output int n);
    n = 0;
    do begin @(posedge clk); n++; end while (sepv !== lvl && n < 1000);
  endtask : wait_sep

  task automatic train(input int on, off, reps, output logic seen);
    seen = 1'b0;
    repeat (reps) begin
      for (int k = 0; k < on + off; k++) begin
        h <= (k < on) ^ pol;
        @(posedge clk);
        if (sepv === 1'b1) seen = 1'b1;
      end
    end
  endtask : train

  task automatic sep_cycle(input logic p, input logic [7:0] t);
    int n;
    int ti;
    logic [31:0] q;
    ti = t;
    bus(1, A_THR, {24'h0, t}, 4'hf, q);
    pol <= p; h <= p;
    repeat (400) @(posedge clk);
    h <= !p;
    wait_sep(1'b1, n);
    `CHK(n > ti * 20 && n <= ti * 20 + 26, 1'b1)
    `CHK(ov, 1'b1)
    bus(0, A_CNT, 0, 4'hf, q);
    `CHK(q, 32'h0)
    repeat (200) @(posedge clk);
    `CHK(sepv, 1'b1)
    h <= p;
    wait_sep(1'b0, n);
    `CHK(n > (ti - 1) * 20 && n <= ti * 20 + 6, 1'b1)
    bus(0, A_CNT, 0, 4'hf, q);
    `CHK(q, 32'h0)
    $display("test separator polarity %0d finished", p);
  endtask : sep_cycle

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] q, r;
    logic        seen, last;
    int          n, rises, mism;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, A_THR, 0, 4'hf, q);
    `CHK(q, {24'h0, `SYNC_SEP_THRESH_RST})
    for (int i = 0; i < 6; i++) begin
      bus(0, 8'({A_PATH, A_SRC, A_STAT, A_CNT, 8'h7c, 8'h39}
                >> (40 - 8 * i)), 0, 4'hf, q);
      `CHK(q, 32'h0)
    end
    bus(1, 8'h39, 32'h11, 4'hf, q);
    bus(1, A_THR, 32'h11, 4'he, q);
    bus(1, A_STAT, 32'hff, 4'hf, q);
    bus(0, A_THR, 0, 4'hf, q);
    `CHK(q, {24'h0, `SYNC_SEP_THRESH_RST})
    bus(0, A_STAT, 0, 4'hf, q);
    `CHK(q, 32'h0)
    r = nxt();
    bus(1, A_THR, r, 4'h1, q);
    bus(0, A_THR, 0, 4'hf, q);
    `CHK(q, {24'h0, r[7:0]})
    $display("test registers finished");
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      bus(1, A_PATH, {30'h0, i[0], 1'b0}, 4'h1, q);
      bus(1, A_SRC, {28'h0, i[1], 1'b0, r[8], i[2]}, 4'h1, q);
      bus(0, A_STAT, 0, 4'hf, q);
      `CHK(q[5], i[2])
      repeat (8) begin
        r = nxt();
        h <= r[0]; v <= r[1]; s <= r[2]; dh <= r[3]; dv <= r[4]; dc <= r[5];
        @(posedge clk);
        @(posedge clk);
        `CHK(oh, pick(i[0], i[1], s, h, dh))
        `CHK(oc, pick(i[0], i[1], s, h, dc))
        `CHK(ov, pick(i[0], i[2], sepv, v, dv))
        `CHK(flag, i[2])
      end
    end
    $display("test muxes finished");
    bus(1, A_PATH, 0, 4'h1, q);
    bus(1, A_SRC, 32'h1, 4'h1, q);
    r = nxt();
    sep_cycle(1'b0, 8'h03);
    sep_cycle(1'b1, 8'h03 + r[2:0]);
    pol <= 1'b0; h <= 1'b0;
    bus(1, A_THR, 32'h4, 4'h1, q);
    train(0, 100, 1, seen);
    train(20, 60, 40, seen);
    `CHK(seen, 1'b0)
    train(60, 20, 10, seen);
    `CHK(seen, 1'b1)
    h <= 1'b0;
    repeat (120) @(posedge clk);
    wait_sep(1'b0, n);
    $display("test short pulses finished");
    bus(1, A_THR, 32'hff, 4'h1, q);
    train(5600, 0, 1, seen);
    `CHK(seen, 1'b0)
    bus(0, A_CNT, 0, 4'hf, q);
    `CHK(q, 32'hff)
    train(0, 5300, 1, seen);
    bus(0, A_CNT, 0, 4'hf, q);
    `CHK(q, 32'h0)
    $display("test saturation finished");
    bus(1, A_THR, 32'h8, 4'h1, q);
    bus(1, A_SRC, 32'h9, 4'h1, q);
    run <= 1'b1;
    rises = 0; mism = 0; last = 1'b0;
    repeat (16000) begin
      @(posedge clk);
      if (sepv === 1'b1 && !last) rises++;
      last = (sepv === 1'b1);
      if (ov !== sepv) mism++;
    end
    `CHK(rises, 2)
    `CHK(mism, 0)
    run <= 1'b0;
    $display("test source frames finished");
    final_report();
  end
endmodule : tb_composite_sync_separator
